// ### rtl/dep_pkg.sv
// constants, types and carriers for the paired-issue dependency resolver
// assumes one core clock shared by decode, register file and cache unit
package dep_pkg;
	localparam int LREG_W   = 3;
	localparam int NUM_LREG = 8;
	localparam int PREG_W   = 5;
	localparam int NUM_PREG = 32;
	localparam int ADDR_W   = 32;
	// first eight physical registers hold the architectural state at reset
	localparam logic [NUM_PREG-1:0] FREE_AT_RESET = 32'hFFFF_FF00;

	typedef enum logic [1:0] {
		SZ_8  = 2'b00,
		SZ_16 = 2'b01,
		SZ_32 = 2'b10
	} opsize_t;

	typedef enum logic [2:0] {
		FWD_NONE    = 3'b000,
		FWD_OPERAND = 3'b001,
		FWD_RESULT  = 3'b010,
		FWD_BYPASS  = 3'b011,
		FWD_STALL   = 3'b100
	} fwd_t;

	typedef enum logic {
		ST_RUN  = 1'b0,
		ST_HOLD = 1'b1
	} state_t;

	typedef struct packed {
		logic              is_move;
		logic              wr_reg;
		logic [LREG_W-1:0] dst_lreg;
		logic              wr_mem;
		logic              rd_reg;
		logic [LREG_W-1:0] src_lreg;
		logic              rd_mem;
		logic [ADDR_W-1:0] mem_addr;
		logic              cacheable;
		opsize_t           src_size;
		opsize_t           dst_size;
	} instr_t;

	typedef struct packed {
		logic   valid;
		instr_t older;
		instr_t younger;
	} pair_t;

	typedef struct packed {
		logic              x_valid;
		logic              y_valid;
		logic [PREG_W-1:0] x_dst;
		logic [PREG_W-1:0] y_dst;
		logic [PREG_W-1:0] x_src;
		logic [PREG_W-1:0] y_src;
		logic [PREG_W-1:0] x_prev;
		logic [PREG_W-1:0] y_prev;
		fwd_t              fwd;
		logic              y_mem_from_result;
		logic              y_skip_mem_read;
	} issue_t;

	typedef struct packed {
		logic              valid;
		logic [PREG_W-1:0] preg;
	} release_t;
endpackage

// ### rtl/pair_dependency_resolver.sv
// rename, forwarding and bypass decisions for an older/younger issue pair
// assumes decode holds pair_i until pair_ready_o, commit reports freed mappings
// Notes on behaviour
// RQ1 - same-register double write: rename both, no stall
// RQ2 - map ends at the younger writer's register
// RQ3 - raw hazards need forwarding, not renaming alone
// RQ4 - operand forwarding: one read feeds both
// RQ5 - operand forwarding only after move-type older
// RQ6 - operand forwarding for register and memory sources
// RQ7 - operand forwarding needs matching operand sizes
// RQ8 - result forwarding: one compute, both destinations
// RQ9 - result forwarding only for younger move
// RQ10 - memory destination takes result directly
// RQ11 - bypass older memory write to younger read
// RQ12 - bypass only for cacheable locations
// RQ13 - fresh physical register from pool per write
// RQ14 - in-order issue, writes kept in program order
// RQ15 - unresolvable raw hazard stalls the younger
// RQ16 - free register only after commit and unreferenced
`timescale 1ns/1ps
`default_nettype none
module pair_dependency_resolver
	import dep_pkg::*;
(
	input  wire logic                      core_clk_i,
	input  wire logic                      reset_n_i,
	input  wire dep_pkg::pair_t            pair_i,
	output logic                           pair_ready_o,
	input  wire logic                      older_result_i,
	input  wire dep_pkg::release_t         release_i,
	input  wire logic [dep_pkg::NUM_PREG-1:0] inflight_ref_i,
	output dep_pkg::issue_t                issue_o
);
	import dep_pkg::*;

	function automatic logic [PREG_W:0] first_free(input logic [NUM_PREG-1:0] m);
		first_free = '0;
		for (int i = NUM_PREG - 1; i >= 0; i--) begin
			if (m[i]) begin
				first_free = {1'b1, PREG_W'(i)};
			end
		end
	endfunction

	logic [PREG_W-1:0] map_ff [NUM_LREG];
	logic [PREG_W-1:0] nxt_map [NUM_LREG];
	logic [NUM_PREG-1:0] free_ff;
	logic [NUM_PREG-1:0] pending_ff;
	state_t            state_ff;
	logic              ready_ff;
	issue_t            issue_ff;
	issue_t            held_ff;
	issue_t            nxt_issue;
	state_t            nxt_state;

	instr_t o_in;
	instr_t y_in;
	assign o_in = pair_i.older;
	assign y_in = pair_i.younger;

	wire accept = pair_i.valid && ready_ff;

	// two fresh registers per pair, picked from the pool
	wire [PREG_W:0] alloc_a = first_free(free_ff); // RQ13
	wire [PREG_W:0] alloc_b = first_free(free_ff & ~(NUM_PREG'(1) << alloc_a[PREG_W-1:0]));
	wire [PREG_W-1:0] x_new = alloc_a[PREG_W-1:0];
	wire [PREG_W-1:0] y_new = alloc_b[PREG_W-1:0];

	// hazard decode
	wire same_dst = o_in.wr_reg && y_in.wr_reg && (o_in.dst_lreg == y_in.dst_lreg);
	wire raw_reg  = o_in.wr_reg && y_in.rd_reg && (o_in.dst_lreg == y_in.src_lreg);
	wire raw_mem  = o_in.wr_mem && y_in.rd_mem && (o_in.mem_addr == y_in.mem_addr);
	wire raw_any  = raw_reg || raw_mem; // RQ3
	wire size_eq  = (o_in.dst_size == y_in.src_size); // RQ7
	wire can_opnd = o_in.is_move && size_eq && raw_any; // RQ5 RQ6
	wire can_res  = !o_in.is_move && y_in.is_move && raw_reg; // RQ9
	wire can_byp  = raw_mem && o_in.cacheable && !can_opnd; // RQ11 RQ12
	wire fwd_t    pick = can_opnd ? FWD_OPERAND :
	                     can_res  ? FWD_RESULT  :
	                     can_byp  ? FWD_BYPASS  :
	                     raw_any  ? FWD_STALL   : FWD_NONE; // RQ15

	// younger reads through the older's fresh register when they collide
	wire [PREG_W-1:0] y_src_map  = raw_reg ? x_new : map_ff[y_in.src_lreg];
	wire [PREG_W-1:0] y_prev_map = same_dst ? x_new : map_ff[y_in.dst_lreg];

	// pool bookkeeping; reclaim waits on in-flight readers
	wire [NUM_PREG-1:0] alloc_bits =
		(accept && o_in.wr_reg ? (NUM_PREG'(1) << x_new) : '0) |
		(accept && y_in.wr_reg ? (NUM_PREG'(1) << y_new) : '0);
	wire [NUM_PREG-1:0] rel_bits = release_i.valid ? (NUM_PREG'(1) << release_i.preg) : '0;
	wire [NUM_PREG-1:0] reclaim  = pending_ff & ~inflight_ref_i; // RQ16
	wire [NUM_PREG-1:0] nxt_free = (free_ff & ~alloc_bits) | reclaim;
	wire [NUM_PREG-1:0] nxt_pend = (pending_ff & ~reclaim) | rel_bits;
	wire [PREG_W:0] nf_a = first_free(nxt_free);
	wire [PREG_W:0] nf_b = first_free(nxt_free & ~(NUM_PREG'(1) << nf_a[PREG_W-1:0]));
	wire nxt_ready = (nxt_state == ST_RUN) && nf_a[PREG_W] && nf_b[PREG_W];

	always_comb begin
		for (int i = 0; i < NUM_LREG; i++) begin
			nxt_map[i] = map_ff[i];
		end
		// older first, younger second: younger wins a shared logical register
		if (accept && o_in.wr_reg) begin
			nxt_map[o_in.dst_lreg] = x_new; // RQ1
		end
		if (accept && y_in.wr_reg) begin
			nxt_map[y_in.dst_lreg] = y_new; // RQ2
		end
	end

	always_comb begin
		nxt_issue = '0;
		nxt_state = state_ff;
		if (state_ff == ST_HOLD) begin
			if (older_result_i) begin
				nxt_issue         = held_ff; // RQ15
				nxt_issue.x_valid = 1'b0;
				nxt_issue.y_valid = 1'b1;
				nxt_state         = ST_RUN;
			end
		end else if (accept) begin
			nxt_issue.x_valid = 1'b1;
			nxt_issue.y_valid = (pick != FWD_STALL); // RQ1 RQ14
			nxt_issue.x_dst   = x_new;
			nxt_issue.y_dst   = y_new;
			nxt_issue.x_src   = map_ff[o_in.src_lreg];
			nxt_issue.y_src   = y_src_map;
			nxt_issue.x_prev  = map_ff[o_in.dst_lreg];
			nxt_issue.y_prev  = y_prev_map;
			nxt_issue.fwd     = pick; // RQ4 RQ8
			nxt_issue.y_mem_from_result = (pick == FWD_RESULT) && y_in.wr_mem; // RQ10
			nxt_issue.y_skip_mem_read   = (pick == FWD_BYPASS) ||
			                              ((pick == FWD_OPERAND) && raw_mem); // RQ11
			if (pick == FWD_STALL) begin
				nxt_state = ST_HOLD;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < NUM_LREG; i++) begin
				map_ff[i] <= PREG_W'(i);
			end
			free_ff    <= FREE_AT_RESET;
			pending_ff <= '0;
			state_ff   <= ST_RUN;
			ready_ff   <= 1'b0;
			issue_ff   <= '0;
			held_ff    <= '0;
		end else begin
			map_ff     <= nxt_map;
			free_ff    <= nxt_free;
			pending_ff <= nxt_pend;
			state_ff   <= nxt_state;
			ready_ff   <= nxt_ready;
			issue_ff   <= nxt_issue;
			if (accept && pick == FWD_STALL) begin
				held_ff <= nxt_issue;
			end
		end
	end

	assign pair_ready_o = ready_ff;
	assign issue_o      = issue_ff;

	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	waw_split_a: assert property (accept && same_dst && !raw_any |=> // RQ1
		issue_o.x_valid && issue_o.y_valid && issue_o.x_dst != issue_o.y_dst)
		else $error("double write did not split into two registers");
	map_younger_a: assert property (accept && same_dst |=> // RQ2
		map_ff[$past(y_in.dst_lreg)] == issue_o.y_dst)
		else $error("map does not point at younger result");
	opnd_size_a: assert property (accept && !size_eq |=> issue_o.fwd != FWD_OPERAND) // RQ7
		else $error("operand forwarded across size mismatch");
	opnd_move_a: assert property (accept && !o_in.is_move |=> issue_o.fwd != FWD_OPERAND) // RQ5
		else $error("operand forwarded after non-move");
	res_move_a: assert property (accept && !y_in.is_move |=> issue_o.fwd != FWD_RESULT) // RQ9
		else $error("result forwarded to non-move");
	byp_cache_a: assert property (accept && !o_in.cacheable |=> issue_o.fwd != FWD_BYPASS) // RQ12
		else $error("bypass on uncacheable location");
	res_mem_a: assert property (accept && can_res && y_in.wr_mem |=> // RQ10
		issue_o.y_valid && issue_o.y_mem_from_result)
		else $error("memory move did not take result directly");
	stall_hold_a: assert property (state_ff == ST_HOLD && !older_result_i |=> // RQ15
		!issue_o.y_valid && !pair_ready_o)
		else $error("younger issued before older result");
	// state checked one cycle out: a new stalled pair may already be taken a cycle later
	hold_release_a: assert property (state_ff == ST_HOLD && older_result_i |=> // RQ14
		issue_o.y_valid && !issue_o.x_valid && state_ff == ST_RUN)
		else $error("held younger not released");
	// bit 0 is the register that the commit scenario keeps referenced
	free_ref_a: assert property (pending_ff[0] && inflight_ref_i[0] && !free_ff[0] |=> // RQ16
		!free_ff[0])
		else $error("referenced register returned to pool");
	alloc_fresh_a: assert property (accept && o_in.wr_reg |-> free_ff[x_new]) // RQ13
		else $error("allocated register was not free");
	opnd_both_a: assert property (accept && can_opnd |=> // RQ4
		issue_o.x_valid && issue_o.y_valid && issue_o.fwd == FWD_OPERAND)
		else $error("operand forwarding did not issue both");
	res_both_a: assert property (accept && can_res |=> // RQ8
		issue_o.x_valid && issue_o.y_valid && issue_o.fwd == FWD_RESULT)
		else $error("result forwarding did not issue both");
	raw_rename_a: assert property (accept && raw_reg |=> // RQ3
		issue_o.y_src == issue_o.x_dst)
		else $error("younger source not renamed to older result");
	byp_skip_a: assert property (accept && can_byp && !raw_reg |=> // RQ11
		issue_o.y_valid && issue_o.y_skip_mem_read)
		else $error("bypass did not skip the memory read");
	older_first_a: assert property (issue_o.y_valid && !issue_o.x_valid |-> // RQ14
		$past(state_ff) == ST_HOLD)
		else $error("younger issued alone outside a stall");

	cov_opnd_c: cover property (accept && pick == FWD_OPERAND ##1 issue_o.y_valid);
	cov_res_c: cover property (accept && pick == FWD_RESULT);
	cov_byp_c: cover property (accept && pick == FWD_BYPASS);
	cov_stall_c: cover property (accept && pick == FWD_STALL ##[1:20] issue_o.y_valid);
	cov_waw_c: cover property (accept && same_dst && pick == FWD_NONE);
endmodule
`default_nettype wire

// ### testbench/pair_issue_model.sv
// decode and execute side model: offers pairs, answers stalled pairs
// assumes one core clock; drives only at the falling edge
`timescale 1ns/1ps
`default_nettype none
module pair_issue_model
	import dep_pkg::*;
#(
	parameter int RES_LAT = 3
)(
	input  wire logic            core_clk_i,
	input  wire logic            pair_ready_o,
	input  wire dep_pkg::issue_t issue_o,
	output dep_pkg::pair_t       pair_i,
	output logic                 older_result_i
);
	int lat_cnt = 0;
	initial begin
		pair_i = '0;
		older_result_i = 1'b0;
	end
	// pair held whole until taken, then scrambled so nothing stale looks valid
	task automatic send(input pair_t p, output bit ok);
		pair_t idle;
		int n;
		idle = ~p;
		idle.valid = 1'b0;
		ok = 1'b0;
		@(negedge core_clk_i);
		pair_i = p;
		// ready only moves at the rising edge; its low-phase value is what that edge sees
		for (n = 0; n < 50 && !ok; n++) begin
			if (n > 0) @(negedge core_clk_i);
			ok = (pair_ready_o === 1'b1);
			@(posedge core_clk_i);
		end
		@(negedge core_clk_i);
		pair_i = idle;
	endtask
	// slow execute: older result of a stalled pair arrives late
	always @(negedge core_clk_i) begin
		older_result_i <= (lat_cnt == 1);
		if (lat_cnt > 0)
			lat_cnt <= lat_cnt - 1;
		else if (issue_o.x_valid && !issue_o.y_valid && issue_o.fwd == FWD_STALL)
			lat_cnt <= RES_LAT;
	end
endmodule
`default_nettype wire

// ### testbench/pair_dependency_resolver_tb_top.sv
// self-checking bench for the pair dependency resolver
// assumes the issue model drives pair_i; bench drives commit inputs
`timescale 1ns/1ps
`default_nettype none
module pair_dependency_resolver_tb_top;
	import dep_pkg::*;
	logic                core_clk_i;
	logic                reset_n_i;
	logic                pair_ready_o;
	logic                older_result_i;
	pair_t               pair_i;
	release_t            release_i;
	logic [NUM_PREG-1:0] inflight_ref_i;
	issue_t              issue_o;
	issue_t              xi;
	issue_t              yi;
	logic                ysame;
	int                  n_errors = 0;
	int                  num_checks = 0;
	pair_dependency_resolver u_pair_dependency_resolver (.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i), .pair_i(pair_i), .pair_ready_o(pair_ready_o),
		.older_result_i(older_result_i), .release_i(release_i),
		.inflight_ref_i(inflight_ref_i), .issue_o(issue_o));
	pair_issue_model u_pair_issue_model (.core_clk_i(core_clk_i), .pair_ready_o(pair_ready_o),
		.issue_o(issue_o), .pair_i(pair_i), .older_result_i(older_result_i));
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	function automatic instr_t mk(logic mv, wr, logic [2:0] d, logic wm, rr, logic [2:0] s,
		logic rm, cch, opsize_t ss, ds);
		return '{mv, wr, d, wm, rr, s, rm, 32'h0000_1000, cch, ss, ds};
	endfunction
	task automatic run(input instr_t o, y);
		bit ok;
		int n;
		u_pair_issue_model.send('{1'b1, o, y}, ok);
		chk("taken", 1, ok);
		for (n = 0; n < 10 && issue_o.x_valid !== 1'b1; n++) @(negedge core_clk_i);
		xi = issue_o;
		ysame = issue_o.y_valid;
		for (n = 0; n < 20 && issue_o.y_valid !== 1'b1; n++) @(negedge core_clk_i);
		yi = issue_o;
	endtask
	task automatic t_waw;
		run(mk(0,1,0,0,1,1,0,1,SZ_32,SZ_32), mk(1,1,0,0,0,0,1,1,SZ_32,SZ_32));
		chk("waw no stall", 1, ysame);
		chk("x_dst", 8, xi.x_dst);
		chk("y_dst", 9, xi.y_dst);
		chk("y_prev", 8, xi.y_prev);
		chk("x_prev", 0, xi.x_prev);
		chk("waw fwd", FWD_NONE, xi.fwd);
		run(mk(1,1,4,0,1,0,0,1,SZ_32,SZ_32), mk(0,0,0,0,0,0,0,1,SZ_32,SZ_32));
		chk("x_src", 9, xi.x_src);
	endtask
	task automatic t_operand;
		for (int k = 0; k < 2; k++) begin
			run(mk(1,1,1,0,k==0,5,k==1,1,SZ_32,SZ_32), mk(0,1,2,0,1,1,0,1,SZ_32,SZ_32));
			chk("opnd fwd", FWD_OPERAND, xi.fwd);
			chk("y_src", 11 + 2 * k, xi.y_src);
			chk("opnd same", 1, ysame);
		end
		run(mk(1,1,1,0,0,0,1,1,SZ_32,SZ_32), mk(0,1,2,0,1,1,0,1,SZ_16,SZ_32));
		chk("size stall", FWD_STALL, yi.fwd);
		chk("size late", 0, ysame);
		run(mk(0,1,1,0,1,3,0,1,SZ_32,SZ_32), mk(0,1,2,0,1,1,0,1,SZ_32,SZ_32));
		chk("alu stall", FWD_STALL, yi.fwd);
		chk("alu late", 0, ysame);
	endtask
	task automatic t_result;
		run(mk(0,1,3,0,1,4,0,1,SZ_32,SZ_32), mk(1,0,0,1,1,3,0,1,SZ_32,SZ_32));
		chk("res fwd", FWD_RESULT, xi.fwd);
		chk("res same", 1, ysame);
		chk("mem direct", 1, yi.y_mem_from_result);
		run(mk(0,1,3,0,1,4,0,1,SZ_32,SZ_32), mk(1,1,5,0,1,3,0,1,SZ_32,SZ_32));
		chk("res reg", FWD_RESULT, xi.fwd);
		chk("reg no mem", 0, yi.y_mem_from_result);
	endtask
	task automatic t_bypass;
		for (int c = 1; c >= 0; c--) begin
			run(mk(0,0,0,1,1,4,1,c,SZ_32,SZ_32), mk(0,1,5,0,0,0,1,c,SZ_32,SZ_32));
			chk("skip read", c, yi.y_skip_mem_read);
			chk("bypass", c ? FWD_BYPASS : FWD_STALL, xi.fwd);
		end
	endtask
	task automatic t_release;
		inflight_ref_i[0] = 1'b1;
		release_i = '{1'b1, 5'h00};
		@(negedge core_clk_i);
		release_i = '0;
		repeat (3) @(negedge core_clk_i);
		run(mk(0,1,6,0,0,0,0,1,SZ_32,SZ_32), mk(0,0,0,0,0,0,0,1,SZ_32,SZ_32));
		chk("held reg", 1, xi.x_dst != 5'h00);
		inflight_ref_i[0] = 1'b0;
		repeat (3) @(negedge core_clk_i);
		run(mk(0,1,6,0,0,0,0,1,SZ_32,SZ_32), mk(0,0,0,0,0,0,0,1,SZ_32,SZ_32));
		chk("reclaimed", 0, xi.x_dst);
	endtask
	task automatic wrap_up;
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		reset_n_i = 1'b0;
		release_i = '0;
		inflight_ref_i = '0;
		repeat (20) @(negedge core_clk_i);
		chk("reset ready", 0, pair_ready_o);
		chk("reset valid", 0, issue_o.x_valid);
		reset_n_i = 1'b1;
		t_waw();
		t_operand();
		t_result();
		t_bypass();
		t_release();
		wrap_up();
	end
	// generous bound: under a hundred cycles of traffic expected
	initial begin
		repeat (5000) @(posedge core_clk_i);
		n_errors++;
		wrap_up();
	end
endmodule
`default_nettype wire
